// >>> qbp_pkg.sv
// constants, types and strap values for the three quasi-bidirectional ports
// assumes one system clock; all peripheral sources share that clock
// Functional notes
// (RQ1) reset leaves every port bit one, pullup only
// (RQ2) bit at one reads external pin level
// (RQ3) written zero drives strong low until one/reset
// (RQ4) zero-to-one gives short strong high, then pullup
// (RQ5) port 4 config register picks io or memory
// (RQ6) port 4 bits 0-3 carry program selects 0-3
// (RQ7) port 4 bits 4-7 carry address bits 16-19
// (RQ8) port 5 bit 0 carries can transmit
// (RQ9) port 5 bit 1 feeds can receive
// (RQ10) port 5 bit 2 timer input; bit 3 none
// (RQ11) port 5 bits 4-7 carry peripheral selects
// (RQ12) port 6 bit 0 carries program select 4
// (RQ13) port 6: selects 5-7, address 20-21, serial 2
// (RQ14) alternate drives pin; reads still return pin
package qbp_pkg;
    // port geometry
    localparam int QBP_WIDTH = 8;
    localparam int QBP_PORTS = 3;
    localparam int QBP_PINS  = QBP_WIDTH * QBP_PORTS;
    // port indices inside the packed pin vectors
    localparam int QBP_IDX_P4 = 0;
    localparam int QBP_IDX_P5 = 1;
    localparam int QBP_IDX_P6 = 2;
    // reset values
    localparam logic [7:0] QBP_LATCH_RST = 8'hFF;
    localparam logic [7:0] QBP_CFG_RST   = 8'h00;
    // port 5 bit 3 has no alternate role
    localparam logic [7:0] QBP_P5_ALT_MASK = 8'hF7;
    // port 5 / port 6 bit positions of pin-fed alternates
    localparam int QBP_P5_CAN_RX  = 1;
    localparam int QBP_P5_TIMER   = 2;
    localparam int QBP_P6_SER_RX  = 6;
    // strong transition driver length
    localparam int QBP_CLK_NS         = 8;
    localparam int QBP_STRONG_HIGH_NS = 16;
    localparam int QBP_STRONG_HIGH_CYC_RAW = (QBP_STRONG_HIGH_NS + QBP_CLK_NS - 1) / QBP_CLK_NS;
    localparam int QBP_STRONG_HIGH_CYC = (QBP_STRONG_HIGH_CYC_RAW < 1) ? 1
                                                                       : QBP_STRONG_HIGH_CYC_RAW;
    localparam int QBP_CNT_W   = 4;
    localparam int QBP_CNT_MAX = (1 << QBP_CNT_W) - 1;

    // memory interface sources: selects 0..7, address bits 16..21
    typedef struct packed {
        logic [5:0] memAddrHi;      // [0]=bit16 .. [5]=bit21
        logic [7:0] progMemSelect;  // [0]=select 0 .. [7]=select 7
    } qbp_mem_t;

    // per-pin cell state
    typedef struct packed {
        logic                 sync1;   // first synchroniser stage
        logic                 sync2;   // second synchroniser stage
        logic                 prevDrv; // drive level last cycle
        logic [QBP_CNT_W-1:0] cnt;     // strong high cycles left
        logic                 out;     // pin output value
        logic                 oe_n;    // pin enable, low drives
    } qbp_cell_t;

    // top state
    typedef struct packed {
        logic [QBP_PINS-1:0] latch;   // port latches, port 4 low
        logic [7:0]          cfg;     // port4_config_reg, 1 = memory role
    } qbp_top_t;
endpackage

// >>> qbp_pin_cell.sv
// one quasi-bidirectional pin driver with input synchroniser
// assumes an external weak pullup; clk_sys domain, synchronous reset
module qbp_pin_cell
    import qbp_pkg::*;
#(
    parameter int STRONG_CYC = QBP_STRONG_HIGH_CYC
) (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst_n,
    // wanted pin level
    input  wire logic drv,
    // pin signals
    input  wire logic pinIn,
    output logic      pinOut,
    output logic      pinOe_n,
    // synchronised pin level
    output logic      rd
);
    qbp_cell_t s_r;   // registered state
    qbp_cell_t s_nxt; // next state

    // refuse pulse lengths the counter cannot hold
    if (STRONG_CYC < 1 || STRONG_CYC > QBP_CNT_MAX) begin : g_bad
        $error("strong pulse length out of range");
    end

    // next-state logic
    always_comb begin
        s_nxt         = s_r;
        s_nxt.sync1   = pinIn;
        s_nxt.sync2   = s_r.sync1;
        s_nxt.prevDrv = drv;
        if (!drv) begin
            // zero: hold strong pulldown
            s_nxt.out  = 1'b0; // RQ3
            s_nxt.oe_n = 1'b0; // RQ3
            s_nxt.cnt  = '0;
        end else if (!s_r.prevDrv) begin
            // rising: start strong high
            s_nxt.out  = 1'b1; // RQ4
            s_nxt.oe_n = 1'b0; // RQ4
            s_nxt.cnt  = QBP_CNT_W'(STRONG_CYC - 1);
        end else if (s_r.cnt != '0) begin
            // keep strong high a while longer
            s_nxt.cnt = s_r.cnt - 1'b1; // RQ4
        end else begin
            // release to weak pullup, pin also an input
            s_nxt.out  = 1'b1; // RQ2
            s_nxt.oe_n = 1'b1; // RQ2
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_r <= '{sync1: 1'b1, sync2: 1'b1, prevDrv: 1'b1, cnt: '0,
                     out: 1'b1, oe_n: 1'b1}; // RQ1
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops
    assign pinOut  = s_r.out;
    assign pinOe_n = s_r.oe_n;
    assign rd      = s_r.sync2; // RQ2

    // low drive follows a zero request
    chk_pull_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
        !drv |=> (!pinOe_n && !pinOut))
        else $error("pin not pulled low");
    // strong high starts one cycle after rise, two cycles while drive stays high
    chk_strong_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
        ((drv && !s_r.prevDrv) ##1 drv) |-> (!pinOe_n && pinOut) ##1 (!pinOe_n && pinOut))
        else $error("strong high missing");
    // released after the pulse when drive stays high
    chk_pulse_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ4
        ((drv && !s_r.prevDrv) ##1 drv ##1 drv) |=> (pinOe_n && pinOut))
        else $error("strong high not released");
    // read returns pin two cycles late
    chk_read_sync: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ2
        ($past(rst_n, 2) && $past(rst_n)) |-> (rd == $past(pinIn, 2)))
        else $error("read level wrong");
endmodule

// >>> qbp_ports.sv
// ports 4, 5 and 6: latches, port 4 role register, alternate muxing
// assumes cpu strobes and peripheral sources on clk_sys; pins are async
module qbp_ports
    import qbp_pkg::*;
#(
    parameter int STRONG_CYC = QBP_STRONG_HIGH_CYC
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                rst_n,
    // cpu port latch writes, one enable per port
    input  wire logic [QBP_PORTS-1:0] portWrEn,
    input  wire logic [7:0]          portWrData,
    // port4_config_reg write and readback
    input  wire logic                cfgWrEn,
    input  wire logic [7:0]          cfgWrData,
    output logic      [7:0]          cfgRd,
    // pin levels as read by software
    output logic      [7:0]          p4Rd,
    output logic      [7:0]          p5Rd,
    output logic      [7:0]          p6Rd,
    // memory interface sources
    input  wire qbp_mem_t            memBus,
    // port 5 alternates
    input  wire logic [7:0]          p5AltEn,
    input  wire logic                can_tx_out,
    input  wire logic [3:0]          periphSelect,
    output logic                     can_rx_in,
    output logic                     timer_three_ext_in,
    // port 6 alternates
    input  wire logic [7:0]          p6AltEn,
    input  wire logic                serial2_tx,
    output logic                     serial2_rx,
    // pins, port 4 in bits 7:0, port 5 in 15:8, port 6 in 23:16
    input  wire logic [QBP_PINS-1:0] pinIn,
    output logic      [QBP_PINS-1:0] pinOut,
    output logic      [QBP_PINS-1:0] pinOe_n
);
    qbp_top_t s_r;   // registered state
    qbp_top_t s_nxt; // next state

    logic [QBP_PINS-1:0] altVal; // alternate function values
    logic [QBP_PINS-1:0] altSel; // alternate function selected
    logic [QBP_PINS-1:0] drv;    // level each cell should present
    logic [QBP_PINS-1:0] rd;     // synchronised pin levels

    // refuse pulse lengths the cells cannot count
    if (STRONG_CYC < 1 || STRONG_CYC > QBP_CNT_MAX) begin : g_bad_cyc
        $error("strong pulse length out of range");
    end

    // next-state: latch writes and role register
    always_comb begin
        s_nxt = s_r;
        for (int p = 0; p < QBP_PORTS; p++) begin
            if (portWrEn[p]) begin
                // a zero holds until a one or reset
                s_nxt.latch[p*QBP_WIDTH +: QBP_WIDTH] = portWrData; // RQ3
            end
        end
        if (cfgWrEn) begin
            s_nxt.cfg = cfgWrData; // RQ5
        end
    end

    // state register
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_r.latch <= {QBP_PORTS{QBP_LATCH_RST}}; // RQ1
            s_r.cfg   <= QBP_CFG_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // alternate values; pin-fed alternates leave the pin released high
    always_comb begin
        altVal = '0;
        altSel = '0;
        // port 4: selects 0-3 then address 16-19
        altVal[QBP_IDX_P4*QBP_WIDTH +: QBP_WIDTH] =
            {memBus.memAddrHi[3:0], memBus.progMemSelect[3:0]}; // RQ6 RQ7
        altSel[QBP_IDX_P4*QBP_WIDTH +: QBP_WIDTH] = s_r.cfg;    // RQ5
        // port 5: can tx, can rx, timer, none, peripheral selects
        altVal[QBP_IDX_P5*QBP_WIDTH +: QBP_WIDTH] =
            {periphSelect, 1'b1, 1'b1, 1'b1, can_tx_out}; // RQ8 RQ9 RQ10 RQ11
        altSel[QBP_IDX_P5*QBP_WIDTH +: QBP_WIDTH] = p5AltEn & QBP_P5_ALT_MASK; // RQ10
        // port 6: selects 4-7, address 20-21, serial rx, serial tx
        altVal[QBP_IDX_P6*QBP_WIDTH +: QBP_WIDTH] =
            {serial2_tx, 1'b1, memBus.memAddrHi[5:4],
             memBus.progMemSelect[7:4]}; // RQ12 RQ13
        altSel[QBP_IDX_P6*QBP_WIDTH +: QBP_WIDTH] = p6AltEn;
        // alternate wins over the latch
        drv = (altSel & altVal) | (~altSel & s_r.latch); // RQ14
    end

    // one driver cell per pin
    for (genvar i = 0; i < QBP_PINS; i++) begin : g_pin
        qbp_pin_cell #(
            .STRONG_CYC (STRONG_CYC)
        ) u_cell (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .drv     (drv[i]),
            .pinIn   (pinIn[i]),
            .pinOut  (pinOut[i]),
            .pinOe_n (pinOe_n[i]),
            .rd      (rd[i])
        );
        // a low drive level reaches its pin one cycle on, whatever its source
        chk_drive_follow: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ14
            !drv[i] |=> (!pinOut[i] && !pinOe_n[i]))
            else $error("pin does not follow low drive");
    end

    // readback: pin level even under an alternate
    assign p4Rd  = rd[QBP_IDX_P4*QBP_WIDTH +: QBP_WIDTH]; // RQ14
    assign p5Rd  = rd[QBP_IDX_P5*QBP_WIDTH +: QBP_WIDTH]; // RQ14
    assign p6Rd  = rd[QBP_IDX_P6*QBP_WIDTH +: QBP_WIDTH]; // RQ14
    assign cfgRd = s_r.cfg;

    // pin-fed peripheral inputs, already synchronised
    assign can_rx_in          = rd[QBP_IDX_P5*QBP_WIDTH + QBP_P5_CAN_RX]; // RQ9
    assign timer_three_ext_in = rd[QBP_IDX_P5*QBP_WIDTH + QBP_P5_TIMER];  // RQ10
    assign serial2_rx         = rd[QBP_IDX_P6*QBP_WIDTH + QBP_P6_SER_RX]; // RQ13

    // reset releases every pin to the pullup
    chk_reset_release: assert property (@(posedge clk_sys) // RQ1
        !rst_n |=> (&pinOe_n && &pinOut))
        else $error("pin driven after reset");
    // written zero reaches the pin two cycles on
    chk_write_low: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
        ((portWrEn[1] && !portWrData[3]) ##1 !portWrEn[1]) |=> (!pinOut[11] && !pinOe_n[11]))
        else $error("port 5 bit 3 not low");
    // port 4 select 0 in memory role
    chk_p4_select: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
        (s_r.cfg[0] && !memBus.progMemSelect[0]) |=> (!pinOut[0] && !pinOe_n[0]))
        else $error("port 4 select 0 wrong");
    // port 4 address 16 in memory role
    chk_p4_addr: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ7
        (s_r.cfg[4] && !memBus.memAddrHi[0]) |=> (!pinOut[4] && !pinOe_n[4]))
        else $error("port 4 address 16 wrong");
    // can transmit on port 5 bit 0
    chk_can_tx: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ8
        (p5AltEn[0] && !can_tx_out) |=> (!pinOut[8] && !pinOe_n[8]))
        else $error("can transmit not on pin");
    // can receive tracks its pin
    chk_can_rx: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
        ($past(rst_n, 2) && $past(rst_n)) |-> (can_rx_in == $past(pinIn[9], 2)))
        else $error("can receive wrong");
    // port 5 bit 3 ignores its alternate enable
    chk_p5_none: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
        (p5AltEn[3] && !s_r.latch[11]) |=> (!pinOut[11] && !pinOe_n[11]))
        else $error("port 5 bit 3 took alternate");
    // peripheral select 0 on port 5 bit 4
    chk_periph_sel: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ11
        (p5AltEn[4] && !periphSelect[0]) |=> (!pinOut[12] && !pinOe_n[12]))
        else $error("peripheral select wrong");
    // program select 4 on port 6 bit 0
    chk_p6_select: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ12
        (p6AltEn[0] && !memBus.progMemSelect[4]) |=> (!pinOut[16] && !pinOe_n[16]))
        else $error("port 6 select 4 wrong");
    // serial transmit on port 6 bit 7
    chk_p6_serial: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        (p6AltEn[7] && !serial2_tx) |=> (!pinOut[23] && !pinOe_n[23]))
        else $error("serial transmit wrong");

    // role register and latch bookkeeping
    // role register reads back what was written
    chk_cfg_read: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
        cfgWrEn |=> (cfgRd == $past(cfgWrData)))
        else $error("role register readback wrong");
    // general role: latch zero drives port 4 bit 0 low
    chk_io_role: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ5
        (!s_r.cfg[0] && !s_r.latch[0]) |=> (!pinOut[0] && !pinOe_n[0]))
        else $error("port 4 general role wrong");
    // a latch zero stays until the port is written
    chk_latch_hold: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ3
        (!s_r.latch[11] && !portWrEn[1]) |=> !s_r.latch[11])
        else $error("latch zero lost");

    // memory role on port 4
    // high select 3 shows high on port 4 bit 3
    chk_select_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ6
        (s_r.cfg[3] && memBus.progMemSelect[3]) |=> pinOut[3])
        else $error("port 4 select 3 wrong");
    // address 19 on port 4 bit 7
    chk_addr_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ7
        (s_r.cfg[7] && !memBus.memAddrHi[3]) |=> (!pinOut[7] && !pinOe_n[7]))
        else $error("port 4 address 19 wrong");

    // port 5 pin-fed alternates keep their driver released high
    chk_rx_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ9
        p5AltEn[1] |=> pinOut[9])
        else $error("can receive pin pulled low");
    chk_timer_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
        p5AltEn[2] |=> pinOut[10])
        else $error("timer pin pulled low");
    // timer input tracks its pin
    chk_timer_in: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ10
        ($past(rst_n, 2) && $past(rst_n)) |-> (timer_three_ext_in == $past(pinIn[10], 2)))
        else $error("timer input wrong");
    // peripheral select 3 on port 5 bit 7
    chk_periph_high: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ11
        (p5AltEn[7] && !periphSelect[3]) |=> (!pinOut[15] && !pinOe_n[15]))
        else $error("peripheral select 3 wrong");

    // port 6 memory and serial alternates
    // program select 7 on port 6 bit 3
    chk_p6_sel_seven: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        (p6AltEn[3] && !memBus.progMemSelect[7]) |=> (!pinOut[19] && !pinOe_n[19]))
        else $error("port 6 select 7 wrong");
    // address 21 on port 6 bit 5
    chk_p6_addr: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        (p6AltEn[5] && !memBus.memAddrHi[5]) |=> (!pinOut[21] && !pinOe_n[21]))
        else $error("port 6 address 21 wrong");
    // serial receive pin stays released
    chk_serial_release: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        p6AltEn[6] |=> pinOut[22])
        else $error("serial receive pin pulled low");
    // serial receive tracks its pin
    chk_serial_rx: assert property (@(posedge clk_sys) disable iff (!rst_n) // RQ13
        ($past(rst_n, 2) && $past(rst_n)) |-> (serial2_rx == $past(pinIn[22], 2)))
        else $error("serial receive wrong");
endmodule

// >>> qbp_pin_env.sv
// far side of the ports: weak pullups and external circuits on 24 pins
// assumes pinOe_n low means the device drives; bench picks external drive
module qbp_pin_env
    import qbp_pkg::*;
(
    // device side
    input  wire logic [QBP_PINS-1:0] pinOut,
    input  wire logic [QBP_PINS-1:0] pinOe_n,
    // external drivers from the bench
    input  wire logic [QBP_PINS-1:0] extEn,
    input  wire logic [QBP_PINS-1:0] extVal,
    // resolved pin levels
    output logic      [QBP_PINS-1:0] pinIn
);
    timeunit 1ns;
    timeprecision 100ps;
    // device wins, else external, else pullup; a clash resolves to x
    always_comb begin
        for (int i = 0; i < QBP_PINS; i++) begin
            if (!pinOe_n[i] && extEn[i] && (pinOut[i] !== extVal[i])) begin
                pinIn[i] = 1'bx;
            end else if (!pinOe_n[i]) begin
                pinIn[i] = pinOut[i];
            end else if (extEn[i]) begin
                pinIn[i] = extVal[i];
            end else begin
                pinIn[i] = 1'b1;
            end
        end
    end
endmodule

// >>> testbench.sv
// self-checking bench for the three quasi-bidirectional ports
// assumes qbp_pin_env resolves pins; inputs change 1 ns after clk_sys rises
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import qbp_pkg::*;
    // design signals
    logic clk_sys, rst_n, cfgWrEn, can_tx_out, serial2_tx;
    logic can_rx_in, timer_three_ext_in, serial2_rx;
    logic [2:0] portWrEn;
    logic [3:0] periphSelect;
    logic [7:0] portWrData, cfgWrData, cfgRd, p4Rd, p5Rd, p6Rd, p5AltEn, p6AltEn, d, m;
    logic [23:0] pinIn, pinOut, pinOe_n, extEn, extVal, rdAll;
    qbp_mem_t memBus;
    int errors, n_checks, p;
    assign rdAll = {p6Rd, p5Rd, p4Rd};
    // design and far side
    qbp_ports dut (.clk_sys(clk_sys), .rst_n(rst_n), .portWrEn(portWrEn),
        .portWrData(portWrData), .cfgWrEn(cfgWrEn), .cfgWrData(cfgWrData), .cfgRd(cfgRd),
        .p4Rd(p4Rd), .p5Rd(p5Rd), .p6Rd(p6Rd), .memBus(memBus), .p5AltEn(p5AltEn),
        .can_tx_out(can_tx_out), .periphSelect(periphSelect), .can_rx_in(can_rx_in),
        .timer_three_ext_in(timer_three_ext_in), .p6AltEn(p6AltEn), .serial2_tx(serial2_tx),
        .serial2_rx(serial2_rx), .pinIn(pinIn), .pinOut(pinOut), .pinOe_n(pinOe_n));
    qbp_pin_env env (.pinOut(pinOut), .pinOe_n(pinOe_n), .extEn(extEn), .extVal(extVal),
        .pinIn(pinIn));
    // clock
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // n edges, then settle 1 ns
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // one latch write to the ports in mask
    task automatic wr(input logic [2:0] msk, input logic [7:0] v);
        portWrEn = msk;
        portWrData = v;
        cyc(1);
        portWrEn = 3'b000;
    endtask
    // expected read of a general port: zeros driven, ones pulled up or overdriven
    function automatic logic [7:0] exp_rd(input logic [7:0] lat, input logic [7:0] en,
                                          input logic [7:0] val);
        return lat & (~en | val);
    endfunction
    // expected port 5 read, all alternates on and latch at zero
    function automatic logic [7:0] exp_p5(input logic [3:0] sel, input logic [1:0] fed,
                                          input logic tx);
        return {sel, 1'b0, fed, tx};
    endfunction
    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog, far beyond the expected 292 cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        errors++;
        complete_run();
    end
    // main sequence
    initial begin
        {rst_n, cfgWrEn, can_tx_out, serial2_tx, portWrEn, periphSelect} = '0;
        {portWrData, cfgWrData, p5AltEn, p6AltEn, extEn, extVal} = '0;
        memBus = '0;
        void'($urandom(34469));
        cyc(6);
        rst_n = 1'b1;
        cyc(3);
        // reset state
        for (int i = 0; i < 3; i++) begin
            check(pinOe_n[i*8 +: 8], 8'hFF);
            check(rdAll[i*8 +: 8], 8'hFF);
        end
        check(cfgRd, 8'h00);
        $display("test reset done");
        // strong low, then short strong high, then pullup only
        wr(3'b001, 8'h00);
        cyc(4);
        check(pinOe_n[7:0], 8'h00);
        check(pinOut[7:0], 8'h00);
        wr(3'b001, 8'hFF);
        cyc(2);
        check(pinOe_n[7:0], 8'h00);
        check(pinOut[7:0], 8'hFF);
        cyc(3);
        check(pinOe_n[7:0], 8'hFF);
        $display("test transition done");
        // random latch values with external overdrive of high bits
        for (int k = 0; k < 20; k++) begin
            p = $urandom_range(2, 0);
            d = 8'($urandom);
            wr(3'(1 << p), d);
            cyc(6);
            check(pinOe_n[p*8 +: 8], d);
            check(pinOut[p*8 +: 8] & ~d, 8'h00);
            m = 8'($urandom) & d;
            extVal = 24'($urandom);
            extEn[p*8 +: 8] = m;
            cyc(3);
            check(rdAll[p*8 +: 8], exp_rd(d, m, extVal[p*8 +: 8]));
            extEn = '0;
        end
        $display("test general io done");
        // all alternates on, latches of ports 5 and 6 at zero
        cfgWrEn = 1'b1;
        cfgWrData = 8'hFF;
        wr(3'b110, 8'h00);
        cfgWrEn = 1'b0;
        p5AltEn = 8'hFF;
        p6AltEn = 8'hFF;
        extEn = 24'h40_0600;
        for (int k = 0; k < 10; k++) begin
            memBus = 14'($urandom);
            {can_tx_out, serial2_tx, periphSelect} = 6'($urandom);
            extVal = 24'($urandom);
            cyc(6);
            check(cfgRd, 8'hFF);
            check(p4Rd, {memBus.memAddrHi[3:0], memBus.progMemSelect[3:0]});
            check(p5Rd, exp_p5(periphSelect, extVal[10:9], can_tx_out));
            check(8'(can_rx_in), 8'(extVal[9]));
            check(8'(timer_three_ext_in), 8'(extVal[10]));
            check(p6Rd, {serial2_tx, extVal[22], memBus.memAddrHi[5:4],
                memBus.progMemSelect[7:4]});
            check(8'(serial2_rx), 8'(extVal[22]));
        end
        // alternates off: latches take the pins back
        extEn = '0;
        p5AltEn = 8'h00;
        p6AltEn = 8'h00;
        cyc(6);
        check(p5Rd, 8'h00);
        check(p6Rd, 8'h00);
        $display("test alternates done");
        // reset in mid-run drops pulldowns on ports 5, 6 and the memory role
        rst_n = 1'b0;
        cyc(2);
        rst_n = 1'b1;
        cyc(3);
        for (int i = 0; i < 3; i++) begin
            check(pinOe_n[i*8 +: 8], 8'hFF);
            check(rdAll[i*8 +: 8], 8'hFF);
        end
        check(cfgRd, 8'h00);
        $display("test reset again done");
        complete_run();
    end
endmodule
